// ==== hw/adcc_cfg.svh ====
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ---------------------------------------------------------------
`define ADCC_OFS_SC1     8'h00
`define ADCC_OFS_SC2     8'h04
`define ADCC_OFS_RES_LO  8'h08
`define ADCC_OFS_RES_HI  8'h0c
`define ADCC_OFS_CMP_LO  8'h10
`define ADCC_OFS_CMP_HI  8'h14
`define ADCC_OFS_IRQ_ST  8'h18
`define ADCC_OFS_IRQ_CLR 8'h1c
`define ADCC_OFS_IRQ_EN  8'h20

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ADCC_SC1_CONV_COMPLETE_FLAG    7
`define ADCC_SC1_IEN     6
`define ADCC_SC1_CONT    5
`define ADCC_SC2_ACT     7
`define ADCC_SC2_TRG     6
`define ADCC_SC2_CFE     5
`define ADCC_SC2_CGE     4

// ---------------------------------------------------------------
// codes and reset values
// ---------------------------------------------------------------
`define ADCC_CH_OFF      5'h1f
`define ADCC_CH_RSVD     5'h1c
`define ADCC_CH_REFH     5'h1d
`define ADCC_CH_REFL     5'h1e
`define ADCC_CH_RST      5'h1f
`define ADCC_SC2_RST     8'h00

// ---------------------------------------------------------------
// timing: one conversion, nominal time in ns and derived cycles
// ---------------------------------------------------------------
`define ADCC_CLK_NS      50
`define ADCC_CONV_NS     2500
`define ADCC_CONV_CYC    ((`ADCC_CONV_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

`endif

// ==== hw/adcc_pkg.sv ====
package adcc_pkg;
    // converter control states
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_BUSY,
        ADCC_DONE
    } adcc_state_type;
endpackage

// ==== hw/adcc_timer.sv ====
`timescale 1ns/1ns
`include "adcc_cfg.svh"

// conversion timer: counts one conversion length after a start
module adcc_timer
    import adcc_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // control
    input wire logic start_i,  // restart count
    input wire logic abort_i,  // stop count
    // status
    output logic done_o        // one-cycle pulse at end
);
    typedef struct packed {
        logic [7:0] cnt;       // cycles left
        logic       run;       // counting
        logic       done;      // end pulse
    } adcc_tmr_type;

    adcc_tmr_type st_ff;
    adcc_tmr_type nxt_st;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (start_i) begin
            // a start beats an abort in the same cycle
            nxt_st.cnt = 8'(`ADCC_CONV_CYC - 1);
            nxt_st.run = 1'b1;
        end else if (abort_i) begin
            nxt_st.run = 1'b0;
        end else if (st_ff.run) begin
            if (st_ff.cnt == 8'h00) begin
                nxt_st.run = 1'b0;
                nxt_st.done = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt - 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done_o = st_ff.done;
endmodule

// ==== hw/adcc_compare.sv ====
`timescale 1ns/1ns

// compare unit: condition and difference for the compare function
module adcc_compare (
    // operands
    input wire logic [11:0] result_i,  // raw conversion result
    input wire logic [11:0] cmp_val_i, // compare value
    input wire logic        ge_i,      // 1: greater or equal
    // outputs
    output logic            hit_o,     // condition true
    output logic [11:0]     diff_o     // result plus -compare
);
    always_comb begin
        // greater-or-equal when ge_i, else strictly less
        hit_o = ge_i ? (result_i >= cmp_val_i) : (result_i < cmp_val_i);
        diff_o = result_i + (~cmp_val_i + 12'h001);
    end
endmodule

// ==== hw/adcc_ctrl.sv ====
`timescale 1ns/1ns
`include "adcc_cfg.svh"

module adcc_ctrl
    import adcc_pkg::*;
(
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        reset_i,
    // register port
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    output logic [31:0]     rdata_o,
    // hardware trigger from periodic counter
    input wire logic        hw_trigger_in_i,
    // analog converter side
    input wire logic [11:0] adc_sample_i,  // raw code at end
    output logic            conv_power_o,  // converter powered
    output logic [4:0]      mux_sel_o,     // input mux code
    output logic            mux_valid_o,   // mux code legal
    output logic            conv_start_o,  // start pulse
    // interrupt
    output logic            irq_o
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        adcc_state_type st;      // control state
        logic [4:0]  channel_select;
        logic        conv_irq_enable;
        logic        continuous_enable;
        logic        conv_complete_flag;
        logic        trigger_select;
        logic        compare_enable;
        logic        compare_greater_equal;
        logic        armed;      // continuous run started
        logic [11:0] result;     // result registers
        logic [11:0] cmp_val;    // compare value
        logic        irq_st;     // sticky event bit
        logic        irq_en;     // interrupt enable
        logic [31:0] rdata;      // read data
        logic        power;      // converter powered
        logic [4:0]  mux;        // mux selection
        logic        mux_ok;     // mux code legal
        logic        start;      // start pulse
        logic        irq;        // interrupt output
    } adcc_ctl_type;

    adcc_ctl_type st_ff;
    adcc_ctl_type nxt_st;

    logic conv_done;   // timer end pulse
    logic cmp_hit;     // compare condition
    logic [11:0] cmp_diff; // compare difference
    logic tmr_start;   // timer start
    logic tmr_abort;   // timer abort

    // ---------------------------------------------------------------
    // submodules
    // ---------------------------------------------------------------
    adcc_timer u_timer (
        .mclk_i (mclk_i),
        .reset_i(reset_i),
        .start_i(tmr_start),
        .abort_i(tmr_abort),
        .done_o (conv_done)
    );

    adcc_compare u_cmp (
        .result_i (adc_sample_i),
        .cmp_val_i(st_ff.cmp_val),
        .ge_i     (st_ff.compare_greater_equal),
        .hit_o    (cmp_hit),
        .diff_o   (cmp_diff)
    );

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        logic sc1_wr;    // write to first control register
        logic off_wr;    // that write turns converter off
        logic hw_go;     // hardware start
        logic start_now; // begin conversion this cycle
        logic event_set; // completion flag rises
        logic clr_lo;    // low result read
        sc1_wr = 1'b0;
        off_wr = 1'b0;
        hw_go = 1'b0;
        start_now = 1'b0;
        event_set = 1'b0;
        clr_lo = 1'b0;

        nxt_st = st_ff;
        nxt_st.start = 1'b0;
        tmr_abort = 1'b0;

        sc1_wr = wr_i && (addr_i == `ADCC_OFS_SC1);
        off_wr = sc1_wr && (wdata_i[4:0] == `ADCC_CH_OFF);
        clr_lo = rd_i && (addr_i == `ADCC_OFS_RES_LO);

        // register writes
        if (sc1_wr) begin
            nxt_st.channel_select = wdata_i[4:0];
            nxt_st.conv_irq_enable = wdata_i[`ADCC_SC1_IEN];
            nxt_st.continuous_enable = wdata_i[`ADCC_SC1_CONT];
            // completion flag itself is not writable
            nxt_st.conv_complete_flag = 1'b0;
            nxt_st.armed = 1'b0;
        end
        if (wr_i && addr_i == `ADCC_OFS_SC2) begin
            // active bit is read-only
            nxt_st.trigger_select = wdata_i[`ADCC_SC2_TRG];
            nxt_st.compare_enable = wdata_i[`ADCC_SC2_CFE];
            nxt_st.compare_greater_equal = wdata_i[`ADCC_SC2_CGE];
        end
        if (wr_i && addr_i == `ADCC_OFS_CMP_LO) begin
            nxt_st.cmp_val[7:0] = wdata_i[7:0];
        end
        if (wr_i && addr_i == `ADCC_OFS_CMP_HI) begin
            nxt_st.cmp_val[11:8] = wdata_i[3:0];
        end
        if (wr_i && addr_i == `ADCC_OFS_IRQ_EN) begin
            nxt_st.irq_en = wdata_i[0];
        end
        if (clr_lo) begin
            nxt_st.conv_complete_flag = 1'b0;
        end

        // any sc1 write aborts the conversion in progress
        if (sc1_wr) begin
            tmr_abort = 1'b1;
            nxt_st.st = ADCC_IDLE;
        end

        // start decision, using the settings now in force
        hw_go = nxt_st.trigger_select && hw_trigger_in_i;
        if (nxt_st.channel_select != `ADCC_CH_OFF) begin
            if (!nxt_st.trigger_select) begin
                start_now = sc1_wr && !off_wr;
            end else begin
                // a pulse during a conversion is not queued
                start_now = hw_go && (nxt_st.st != ADCC_BUSY);
            end
        end

        // conversion sequence
        unique case (st_ff.st)
            ADCC_IDLE: begin
            end
            ADCC_BUSY: begin
                if (conv_done && !sc1_wr) begin
                    nxt_st.st = ADCC_DONE;
                    if (!st_ff.compare_enable) begin
                        event_set = 1'b1;
                        nxt_st.result = adc_sample_i;
                    end else if (cmp_hit) begin
                        event_set = 1'b1;
                        nxt_st.result = cmp_diff;
                    end
                end
            end
            ADCC_DONE: begin
                // continuous mode restarts, else goes to low power
                if (!sc1_wr && st_ff.continuous_enable &&
                        st_ff.armed &&
                        st_ff.channel_select != `ADCC_CH_OFF) begin
                    start_now = 1'b1;
                end else if (!sc1_wr) begin
                    nxt_st.st = ADCC_IDLE;
                end
            end
        endcase

        if (event_set) begin
            // set beats a clear in the same cycle
            nxt_st.conv_complete_flag = 1'b1;
            if (st_ff.conv_irq_enable) begin
                nxt_st.irq_st = 1'b1;
            end
        end
        // clear register, set wins over clear
        if (wr_i && addr_i == `ADCC_OFS_IRQ_CLR && wdata_i[0] &&
                !(event_set && st_ff.conv_irq_enable)) begin
            nxt_st.irq_st = 1'b0;
        end

        if (start_now) begin
            nxt_st.st = ADCC_BUSY;
            nxt_st.start = 1'b1;
            nxt_st.armed = 1'b1;
        end
        tmr_start = start_now;

        // converter power and mux
        nxt_st.power = (nxt_st.st == ADCC_BUSY);
        nxt_st.mux = nxt_st.channel_select;
        nxt_st.mux_ok = (nxt_st.channel_select != `ADCC_CH_OFF) &&
                        (nxt_st.channel_select != `ADCC_CH_RSVD);
        nxt_st.irq = nxt_st.irq_st && nxt_st.irq_en;

        // read data, one cycle after the strobe
        nxt_st.rdata = 32'h0000_0000;
        if (rd_i) begin
            unique case (addr_i)
                `ADCC_OFS_SC1: nxt_st.rdata[7:0] = {
                    st_ff.conv_complete_flag, st_ff.conv_irq_enable,
                    st_ff.continuous_enable, st_ff.channel_select};
                `ADCC_OFS_SC2: nxt_st.rdata[7:0] = {
                    st_ff.st == ADCC_BUSY, st_ff.trigger_select,
                    st_ff.compare_enable, st_ff.compare_greater_equal,
                    4'h0};
                `ADCC_OFS_RES_LO: nxt_st.rdata[7:0] = st_ff.result[7:0];
                `ADCC_OFS_RES_HI: nxt_st.rdata[3:0] = st_ff.result[11:8];
                `ADCC_OFS_CMP_LO: nxt_st.rdata[7:0] = st_ff.cmp_val[7:0];
                `ADCC_OFS_CMP_HI: nxt_st.rdata[3:0] = st_ff.cmp_val[11:8];
                `ADCC_OFS_IRQ_ST: nxt_st.rdata[0] = st_ff.irq_st;
                `ADCC_OFS_IRQ_EN: nxt_st.rdata[0] = st_ff.irq_en;
                // unmapped and write-only offsets read zero
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_ff <= '0;
            st_ff.st <= ADCC_IDLE;
            st_ff.channel_select <= `ADCC_CH_RST;
            st_ff.mux <= `ADCC_CH_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all from flip-flops
    // ---------------------------------------------------------------
    assign rdata_o = st_ff.rdata;
    assign conv_power_o = st_ff.power;
    assign mux_sel_o = st_ff.mux;
    assign mux_valid_o = st_ff.mux_ok;
    assign conv_start_o = st_ff.start;
    assign irq_o = st_ff.irq;
endmodule

// ==== verif/adcc_ctrl_properties.sv ====
`timescale 1ns/1ns
`include "adcc_cfg.svh"

// ---------------------------------------------------------------
// port-level checks of the conversion control block
// ---------------------------------------------------------------
module adcc_ctrl_properties (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // trigger and converter side
    input wire logic hw_trigger_in_i,
    input wire logic [11:0] adc_sample_i,
    input wire logic conv_power_o,
    input wire logic [4:0] mux_sel_o,
    input wire logic mux_valid_o,
    input wire logic conv_start_o,
    input wire logic irq_o
);
    localparam int CONV = `ADCC_CONV_CYC;
    logic trg_ff;       // shadow of trigger select
    logic irq_en_ff;    // shadow of interrupt enable
    logic [7:0] busy_ff; // cycles since last start, saturating
    wire sc1_wr = wr_i && addr_i == `ADCC_OFS_SC1;

    // shadows follow software writes, so no peeking inside
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            trg_ff <= 1'b0;
            irq_en_ff <= 1'b0;
            busy_ff <= 8'h00;
        end else begin
            if (wr_i && addr_i == `ADCC_OFS_SC2) begin
                trg_ff <= wdata_i[`ADCC_SC2_TRG];
            end
            if (wr_i && addr_i == `ADCC_OFS_IRQ_EN) begin
                irq_en_ff <= wdata_i[0];
            end
            if (conv_start_o) begin
                busy_ff <= 8'h01;
            end else if (busy_ff != 8'hff) begin
                busy_ff <= busy_ff + 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_sw_write_start: assert property (@(posedge mclk_i)
        disable iff (reset_i) sc1_wr && !trg_ff &&
        wdata_i[4:0] != `ADCC_CH_OFF |=> conv_start_o)
        else $error("no start after control write");
    a_off_stays_idle: assert property (@(posedge mclk_i)
        disable iff (reset_i) sc1_wr && wdata_i[4:0] == `ADCC_CH_OFF
        |=> !conv_start_o && !conv_power_o)
        else $error("converter busy after off write");
    a_mux_follows: assert property (@(posedge mclk_i)
        disable iff (reset_i) sc1_wr |=> mux_sel_o == $past(wdata_i[4:0]))
        else $error("mux code differs from channel written");
    a_mux_legal: assert property (@(posedge mclk_i)
        disable iff (reset_i) mux_valid_o ==
        !(mux_sel_o inside {`ADCC_CH_OFF, `ADCC_CH_RSVD}))
        else $error("mux valid wrong for code");
    a_start_powers: assert property (@(posedge mclk_i)
        disable iff (reset_i) conv_start_o |-> conv_power_o)
        else $error("start without power");
    a_conv_bounded: assert property (@(posedge mclk_i)
        disable iff (reset_i) conv_power_o && !conv_start_o
        |-> busy_ff <= CONV + 1)
        else $error("converter stays powered too long");
    a_hw_start: assert property (@(posedge mclk_i)
        disable iff (reset_i) trg_ff && hw_trigger_in_i && !wr_i &&
        mux_valid_o && !conv_power_o && !$past(conv_power_o) &&
        !$past(conv_power_o, 2) |=> conv_start_o)
        else $error("hardware trigger ignored");
    a_start_pulse: assert property (@(posedge mclk_i)
        disable iff (reset_i) conv_start_o && !wr_i |=> !conv_start_o)
        else $error("start pulse too long");
    a_irq_masked: assert property (@(posedge mclk_i)
        disable iff (reset_i) (!irq_en_ff) [*2] |-> !irq_o)
        else $error("interrupt while disabled");
endmodule

// ==== verif/adcc_ctrl_tb.sv ====
`timescale 1ns/1ns
`include "adcc_cfg.svh"

module adcc_ctrl_tb;
    localparam int CONV = `ADCC_CONV_CYC;
    // compare cases: control two, sample, flag, result
    localparam logic [7:0] C2 [5] = '{8'h30, 8'h30, 8'h20, 8'h20, 8'h30};
    localparam logic [11:0] SM [5] = '{12'h500, 12'h300, 12'h300,
        12'h400, 12'h400};
    localparam logic FL [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    localparam logic [11:0] RS [5] = '{12'h100, 12'h100, 12'hf00,
        12'hf00, 12'h000};
    localparam logic [4:0] CH [8] = '{5'h00, 5'h0f, 5'h10, 5'h1b,
        5'h1c, 5'h1d, 5'h1e, 5'h1f};
    logic mclk_i, reset_i, wr_i, rd_i, hw_trigger_in_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, rv;
    logic [11:0] adc_sample_i;
    logic conv_power_o, mux_valid_o, conv_start_o, irq_o;
    logic [4:0] mux_sel_o;
    int mismatches, tests_run, n, starts, s0;

    adcc_ctrl DUT (.mclk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .hw_trigger_in_i, .adc_sample_i, .conv_power_o,
        .mux_sel_o, .mux_valid_o, .conv_start_o, .irq_o);

    // ---------------------------------------------------------------
    // clock, start counter, watchdog
    // ---------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) if (conv_start_o === 1'b1) starts++;
    // whole run is under 1000 cycles, so this is ample
    initial begin
        #(50 * 40000);
        mismatches++;
        end_of_test;
    end

    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, e);
        tests_run++;
        if (seen !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
        input string nm);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
        chk(nm, rv, e);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    // waits for a conversion and counts its powered cycles
    task automatic run_conv(output int c);
        c = 0;
        while (conv_power_o !== 1'b1 && c < 10) begin
            tick(1);
            c++;
        end
        c = 0;
        while (conv_power_o === 1'b1 && c < 200) begin
            tick(1);
            c++;
        end
        tick(3);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        {reset_i, wr_i, rd_i, hw_trigger_in_i} = 4'h8;
        {addr_i, wdata_i, adc_sample_i} = '0;
        {mismatches, tests_run, starts} = '0;
        repeat (5) @(posedge mclk_i);
        reset_i <= 1'b0;
        rchk(`ADCC_OFS_SC1, 32'h1f, "sc1 reset");
        rchk(`ADCC_OFS_SC2, 32'h0, "sc2 reset");
        rchk(8'h30, 32'h0, "unmapped read");
        $display("test reset done");
        // software single conversion with interrupt
        adc_sample_i <= 12'h5a3;
        wr(`ADCC_OFS_IRQ_EN, 32'h1);
        s0 = starts;
        wr(`ADCC_OFS_SC1, 32'h43);
        rchk(`ADCC_OFS_SC2, 32'h80, "active set");
        run_conv(n);
        chk("conv length", {31'h0, n >= CONV - 1 && n <= CONV + 1}, 1);
        tick(20);
        chk("single start", starts - s0, 1);
        rchk(`ADCC_OFS_SC1, 32'hc3, "flag set");
        chk("irq high", {31'h0, irq_o}, 1);
        rchk(`ADCC_OFS_RES_HI, 32'h5, "result high");
        rchk(`ADCC_OFS_RES_LO, 32'ha3, "result low");
        rchk(`ADCC_OFS_SC1, 32'h43, "flag cleared by read");
        wr(`ADCC_OFS_IRQ_CLR, 32'h1);
        tick(2);
        chk("irq cleared", {31'h0, irq_o}, 0);
        $display("test single done");
        // abort, read-only flag, switch off
        wr(`ADCC_OFS_SC1, 32'h05);
        tick(10);
        wr(`ADCC_OFS_SC1, 32'h87);
        rchk(`ADCC_OFS_SC1, 32'h07, "flag not writable");
        wr(`ADCC_OFS_SC1, 32'h1f);
        rchk(`ADCC_OFS_SC2, 32'h0, "active cleared");
        tick(60);
        rchk(`ADCC_OFS_SC1, 32'h1f, "no flag after off");
        rchk(`ADCC_OFS_IRQ_ST, 32'h0, "no irq after off");
        $display("test abort done");
        // channel codes reach the mux
        foreach (CH[i]) begin
            wr(`ADCC_OFS_SC1, {27'h0, CH[i]});
            tick(1);
            chk("mux code", {27'h0, mux_sel_o}, {27'h0, CH[i]});
            chk("mux valid", {31'h0, mux_valid_o},
                {31'h0, CH[i] != 5'h1f && CH[i] != 5'h1c});
        end
        $display("test channels done");
        // compare: greater-equal, less, and equal boundaries
        wr(`ADCC_OFS_CMP_LO, 32'h00);
        wr(`ADCC_OFS_CMP_HI, 32'h04);
        foreach (C2[i]) begin
            wr(`ADCC_OFS_SC2, {24'h0, C2[i]});
            adc_sample_i <= SM[i];
            wr(`ADCC_OFS_SC1, 32'h02);
            run_conv(n);
            rchk(`ADCC_OFS_SC1, {24'h0, FL[i], 7'h02}, "cmp flag");
            rchk(`ADCC_OFS_RES_HI, {28'h0, RS[i][11:8]}, "cmp hi");
            rchk(`ADCC_OFS_RES_LO, {24'h0, RS[i][7:0]}, "cmp lo");
        end
        $display("test compare done");
        // continuous software conversions, then stop with off code
        wr(`ADCC_OFS_SC2, 32'h0);
        wr(`ADCC_OFS_SC1, 32'h21);
        run_conv(n);
        chk("continuous restart", {31'h0, conv_power_o}, 1);
        wr(`ADCC_OFS_SC1, 32'h3f);
        s0 = starts;
        tick(60);
        chk("stopped", starts - s0, 0);
        $display("test continuous done");
        // hardware trigger, single mode
        wr(`ADCC_OFS_SC2, 32'h40);
        wr(`ADCC_OFS_SC1, 32'h04);
        run_conv(n);
        s0 = starts;
        @(posedge mclk_i);
        hw_trigger_in_i <= 1'b1;
        @(posedge mclk_i);
        hw_trigger_in_i <= 1'b0;
        run_conv(n);
        tick(20);
        chk("hw one start", starts - s0, 1);
        rchk(`ADCC_OFS_SC1, 32'h84, "hw flag");
        $display("test hardware done");
        end_of_test;
    end
endmodule

bind adcc_ctrl adcc_ctrl_properties u_props (.mclk_i, .reset_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .hw_trigger_in_i, .adc_sample_i,
    .conv_power_o, .mux_sel_o, .mux_valid_o, .conv_start_o, .irq_o);
